// ### hdl/pcp_pkg.sv
// Package: constants for the seven-pin general-purpose port
package pcp_pkg;
  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int PCP_WIDTH = 8;
  localparam int PCP_BIT_OSC_OUT = 0;
  localparam int PCP_BIT_OSC_IN = 1;
  localparam int PCP_BIT_CCP = 2;
  localparam int PCP_BIT_ABSENT = 3;
  localparam int PCP_BIT_USB_MINUS = 4;
  localparam int PCP_BIT_USB_PLUS = 5;
  localparam int PCP_BIT_SER_CLK = 6;
  localparam int PCP_BIT_SER_DATA = 7;
  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PCP_PIN_MASK = 8'hF7;
  localparam logic [7:0] PCP_CTRL_MASK = 8'hC7;
  localparam logic [7:0] PCP_DIR_RESET = 8'hC7;
  localparam logic [7:0] PCP_LATCH_RESET = 8'h00;
  localparam logic [7:0] PCP_PIN_RESET = 8'h00;
endpackage : pcp_pkg

// ### hdl/pcp_pin_cell.sv
// Module: drive and read selection for one pin of the port
`timescale 1ns/1ps
`default_nettype none
module pcp_pin_cell (
  // Port registers
  input wire logic dir_bit,
  input wire logic latch_bit,
  // Peripheral override
  input wire logic ovr_en,
  input wire logic ovr_oe,
  input wire logic ovr_out,
  input wire logic dig_en,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic rd_bit
);
  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Override never touches the stored direction bit, only the pad
  always_comb begin
    if (!dig_en) begin
      pad_oe = 1'b0;
      pad_out = 1'b0;
    end else if (ovr_en) begin
      pad_oe = ovr_oe;
      pad_out = ovr_out;
    end else begin
      pad_oe = ~dir_bit;
      pad_out = latch_bit;
    end
    rd_bit = dig_en ? pad_in : 1'b0;
  end
endmodule : pcp_pin_cell
`default_nettype wire

// ### hdl/pcp_port.sv
// Module: seven-pin bidirectional port with pin-sharing peripherals
// Function
// (RL1) Direction 1 floats the pin; direction 0 drives the output latch.
// (RL2) Eight bit positions, seven pins; position 3 has no pin.
// (RL3) Latch register reads back the latched value, not the pin level.
// (RL4) USB-shared bits 4 and 5 have no direction bits; port use is input only.
// (RL5) External transceiver selected: bits 4 and 5 are always inputs.
// (RL6) On-chip transceiver: bits 4 and 5 direction follows the USB module.
// (RL7) External transceiver enabled: bit 1 drives the transceiver output enable.
// (RL8) After reset all pins but bits 4 and 5 are digital inputs.
// (RL9) Software disables USB and on-chip transceiver to read bits 4 and 5.
// (RL10) Direction register reads its stored contents despite peripheral overrides.
// (RL11) A peripheral may force a pin's direction without changing the stored bit.
// (RL12) Bit 2: compare/PWM output wins when direction 0; direction 1 feeds capture.
// (RL13) Timer oscillator enabled: bits 0 and 1 lose digital I/O.
// (RL14) Bit 6: async transmit wins over port data; software sets direction 0.
// (RL15) Sync mode: bit 6 clock output when direction 0, input when 1.
// (RL16) Bit 7: receive and sync data; software keeps direction 1.
// (RL17) Bits 4 and 5 port input disabled while USB or on-chip transceiver on.
// (RL18) Unimplemented bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module pcp_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register writes
  input wire logic dir_wr_en,
  input wire logic latch_wr_en,
  input wire logic [7:0] reg_wr_data,
  // Register reads
  output logic [7:0] direction_reg,
  output logic [7:0] output_latch_reg,
  output logic [7:0] pin_level_reg,
  // Pads
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  // Timer oscillator
  input wire logic timer_osc_en,
  output logic timer_count_in,
  // Capture/compare/PWM unit
  input wire logic ccp_out_en,
  input wire logic ccp_out,
  output logic ccp_capture_in,
  // Serial transceiver unit
  input wire logic serial_en,
  input wire logic serial_sync,
  input wire logic serial_tx_data,
  input wire logic sync_serial_clock_out,
  input wire logic sync_serial_data_out,
  input wire logic sync_serial_data_oe,
  output logic sync_serial_clock_in,
  output logic serial_rx_data,
  // USB module
  input wire logic usb_module_enable,
  input wire logic usb_xcvr_disable,
  input wire logic usb_ext_xcvr,
  input wire logic xcvr_output_enable,
  input wire logic usb_drive,
  input wire logic usb_minus_out,
  input wire logic usb_plus_out,
  output logic usb_minus_in,
  output logic usb_plus_in,
  output logic ext_xcvr_minus_in,
  output logic ext_xcvr_plus_in
);
  // ----------------------------------------------------------------
  // Override selection
  // ----------------------------------------------------------------
  logic ext_sel;
  logic int_sel;
  logic usb_port_off;
  logic [7:0] ovr_en;
  logic [7:0] ovr_oe;
  logic [7:0] ovr_out;
  logic [7:0] dig_en;
  logic [7:0] cell_out;
  logic [7:0] cell_oe;
  logic [7:0] cell_rd;
  logic [7:0] pad_out_next;
  logic [7:0] pad_oe_next;
  logic [7:0] pin_level_next;

  assign ext_sel = usb_module_enable & usb_ext_xcvr;
  assign int_sel = usb_module_enable & ~usb_ext_xcvr;
  // On-chip transceiver live unless its disable bit is set
  assign usb_port_off = usb_module_enable | ~usb_xcvr_disable; // see (RL17) (RL9)

  always_comb begin
    ovr_en = 8'h00;
    ovr_oe = 8'h00;
    ovr_out = 8'h00;
    dig_en = pcp_pkg::PCP_CTRL_MASK; // see (RL2)
    // Oscillator pins are analog: digital path shut off
    if (timer_osc_en) begin
      dig_en[pcp_pkg::PCP_BIT_OSC_OUT] = 1'b0; // see (RL13)
      dig_en[pcp_pkg::PCP_BIT_OSC_IN] = 1'b0; // see (RL13)
    end
    if (ext_sel) begin
      ovr_en[pcp_pkg::PCP_BIT_OSC_IN] = 1'b1; // see (RL7) (RL11)
      ovr_oe[pcp_pkg::PCP_BIT_OSC_IN] = 1'b1;
      ovr_out[pcp_pkg::PCP_BIT_OSC_IN] = xcvr_output_enable;
    end
    if (ccp_out_en && !direction_reg[pcp_pkg::PCP_BIT_CCP]) begin
      ovr_en[pcp_pkg::PCP_BIT_CCP] = 1'b1; // see (RL12)
      ovr_oe[pcp_pkg::PCP_BIT_CCP] = 1'b1;
      ovr_out[pcp_pkg::PCP_BIT_CCP] = ccp_out;
    end
    if (serial_en && !direction_reg[pcp_pkg::PCP_BIT_SER_CLK]) begin
      ovr_en[pcp_pkg::PCP_BIT_SER_CLK] = 1'b1; // see (RL14) (RL15)
      ovr_oe[pcp_pkg::PCP_BIT_SER_CLK] = 1'b1;
      ovr_out[pcp_pkg::PCP_BIT_SER_CLK] =
        serial_sync ? sync_serial_clock_out : serial_tx_data;
    end
    // Data pin turns around under the serial unit's own control
    if (serial_en && serial_sync) begin
      ovr_en[pcp_pkg::PCP_BIT_SER_DATA] = 1'b1; // see (RL16) (RL11)
      ovr_oe[pcp_pkg::PCP_BIT_SER_DATA] = sync_serial_data_oe;
      ovr_out[pcp_pkg::PCP_BIT_SER_DATA] = sync_serial_data_out;
    end
  end

  // ----------------------------------------------------------------
  // Pin cells for the pins with direction bits
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < pcp_pkg::PCP_WIDTH; gi++) begin : g_pin
      if (pcp_pkg::PCP_CTRL_MASK[gi]) begin : g_cell
        pcp_pin_cell u_cell (
          .dir_bit(direction_reg[gi]),
          .latch_bit(output_latch_reg[gi]),
          .ovr_en(ovr_en[gi]),
          .ovr_oe(ovr_oe[gi]),
          .ovr_out(ovr_out[gi]),
          .dig_en(dig_en[gi]),
          .pad_in(pad_in[gi]),
          .pad_out(cell_out[gi]),
          .pad_oe(cell_oe[gi]),
          .rd_bit(cell_rd[gi])
        ); // see (RL1)
      end else begin : g_none
        assign cell_out[gi] = 1'b0;
        assign cell_oe[gi] = 1'b0;
        assign cell_rd[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // USB-shared pins
  // ----------------------------------------------------------------
  always_comb begin
    pad_out_next = cell_out;
    pad_oe_next = cell_oe;
    pin_level_next = cell_rd;
    // Only the on-chip transceiver ever drives these pins
    pad_oe_next[pcp_pkg::PCP_BIT_USB_MINUS] = int_sel & usb_drive; // see (RL5) (RL6) (RL4)
    pad_oe_next[pcp_pkg::PCP_BIT_USB_PLUS] = int_sel & usb_drive; // see (RL5) (RL6) (RL4)
    pad_out_next[pcp_pkg::PCP_BIT_USB_MINUS] = int_sel & usb_minus_out;
    pad_out_next[pcp_pkg::PCP_BIT_USB_PLUS] = int_sel & usb_plus_out;
    pin_level_next[pcp_pkg::PCP_BIT_USB_MINUS] =
      usb_port_off ? 1'b0 : pad_in[pcp_pkg::PCP_BIT_USB_MINUS]; // see (RL17)
    pin_level_next[pcp_pkg::PCP_BIT_USB_PLUS] =
      usb_port_off ? 1'b0 : pad_in[pcp_pkg::PCP_BIT_USB_PLUS]; // see (RL17)
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      direction_reg <= pcp_pkg::PCP_DIR_RESET; // see (RL8)
    end else if (dir_wr_en) begin
      direction_reg <= reg_wr_data & pcp_pkg::PCP_CTRL_MASK; // see (RL18) (RL10)
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      output_latch_reg <= pcp_pkg::PCP_LATCH_RESET;
    end else if (latch_wr_en) begin
      output_latch_reg <= reg_wr_data & pcp_pkg::PCP_CTRL_MASK; // see (RL3) (RL18)
    end
  end

  // Sampled one cycle after the pad; reads never stall on the pad
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_level_reg <= pcp_pkg::PCP_PIN_RESET;
    end else begin
      pin_level_reg <= pin_level_next & pcp_pkg::PCP_PIN_MASK; // see (RL2) (RL18)
    end
  end

  // Pad drive registered; inputs everywhere while in reset
  always_ff @(posedge clock) begin
    if (rst) begin
      pad_out <= 8'h00;
      pad_oe <= 8'h00; // see (RL8)
    end else begin
      pad_out <= pad_out_next;
      pad_oe <= pad_oe_next;
    end
  end

  // Peripheral inputs, registered alongside the pin level
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_count_in <= 1'b0;
      ccp_capture_in <= 1'b0;
      sync_serial_clock_in <= 1'b0;
      serial_rx_data <= 1'b0;
      usb_minus_in <= 1'b0;
      usb_plus_in <= 1'b0;
      ext_xcvr_minus_in <= 1'b0;
      ext_xcvr_plus_in <= 1'b0;
    end else begin
      timer_count_in <= pad_in[pcp_pkg::PCP_BIT_OSC_OUT];
      ccp_capture_in <= pad_in[pcp_pkg::PCP_BIT_CCP]; // see (RL12)
      sync_serial_clock_in <= pad_in[pcp_pkg::PCP_BIT_SER_CLK]; // see (RL15)
      serial_rx_data <= pad_in[pcp_pkg::PCP_BIT_SER_DATA]; // see (RL16)
      usb_minus_in <= int_sel & pad_in[pcp_pkg::PCP_BIT_USB_MINUS]; // see (RL6)
      usb_plus_in <= int_sel & pad_in[pcp_pkg::PCP_BIT_USB_PLUS]; // see (RL6)
      ext_xcvr_minus_in <= ext_sel & pad_in[pcp_pkg::PCP_BIT_USB_MINUS]; // see (RL5)
      ext_xcvr_plus_in <= ext_sel & pad_in[pcp_pkg::PCP_BIT_USB_PLUS]; // see (RL5)
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_plain_pin6;
    !serial_en && !direction_reg[pcp_pkg::PCP_BIT_SER_CLK];
  endsequence

  sequence s_pin6_driven;
    pad_oe[pcp_pkg::PCP_BIT_SER_CLK] &&
      pad_out[pcp_pkg::PCP_BIT_SER_CLK] == $past(output_latch_reg[pcp_pkg::PCP_BIT_SER_CLK]);
  endsequence

  a_dir_drives_latch: assert property (@(posedge clock) disable iff (rst) // see (RL1)
    s_plain_pin6 |=> s_pin6_driven)
    else $error("pin 6 not driving latch with direction 0");

  a_dir_floats_pin: assert property (@(posedge clock) disable iff (rst) // see (RL1)
    direction_reg[0] && !timer_osc_en |=> !pad_oe[0])
    else $error("pin 0 driven with direction 1");

  a_absent_bit_zero: assert property (@(posedge clock) disable iff (rst) // see (RL2) (RL18)
    !pad_oe[pcp_pkg::PCP_BIT_ABSENT] && !pin_level_reg[pcp_pkg::PCP_BIT_ABSENT]
      && !direction_reg[pcp_pkg::PCP_BIT_ABSENT])
    else $error("absent bit 3 active");

  a_latch_readback: assert property (@(posedge clock) disable iff (rst) // see (RL3)
    latch_wr_en |=> output_latch_reg == ($past(reg_wr_data) & pcp_pkg::PCP_CTRL_MASK))
    else $error("latch readback differs from write");

  a_dir_kept_override: assert property (@(posedge clock) disable iff (rst) // see (RL10) (RL11)
    !dir_wr_en |=> $stable(direction_reg))
    else $error("direction changed without a write");

  a_usb_ext_input: assert property (@(posedge clock) disable iff (rst) // see (RL5)
    ext_sel |=> !pad_oe[pcp_pkg::PCP_BIT_USB_MINUS] && !pad_oe[pcp_pkg::PCP_BIT_USB_PLUS])
    else $error("usb pins driven with external transceiver");

  a_usb_int_follows: assert property (@(posedge clock) disable iff (rst) // see (RL6) (RL4)
    int_sel |=> pad_oe[pcp_pkg::PCP_BIT_USB_PLUS] == $past(usb_drive))
    else $error("usb pin direction not following module");

  a_xcvr_oe_pin: assert property (@(posedge clock) disable iff (rst) // see (RL7)
    ext_sel && !timer_osc_en |=> pad_oe[1] && pad_out[1] == $past(xcvr_output_enable))
    else $error("transceiver output enable not on bit 1");

  a_reset_inputs: assert property (@(posedge clock) // see (RL8)
    $fell(rst) |-> direction_reg == pcp_pkg::PCP_DIR_RESET && pad_oe == 8'h00)
    else $error("pins not inputs after reset");

  a_ccp_priority: assert property (@(posedge clock) disable iff (rst) // see (RL12)
    ccp_out_en && !direction_reg[2] |=> pad_oe[2] && pad_out[2] == $past(ccp_out))
    else $error("compare output lost priority on bit 2");

  a_osc_no_digital: assert property (@(posedge clock) disable iff (rst) // see (RL13)
    timer_osc_en |=> !pad_oe[0] && !pad_oe[1] && !pin_level_reg[0] && !pin_level_reg[1])
    else $error("digital io active under oscillator");

  a_tx_priority: assert property (@(posedge clock) disable iff (rst) // see (RL14)
    serial_en && !serial_sync && !direction_reg[6] |=>
      pad_oe[6] && pad_out[6] == $past(serial_tx_data))
    else $error("transmit lost priority on bit 6");

  a_sync_clk_input: assert property (@(posedge clock) disable iff (rst) // see (RL15)
    serial_en && serial_sync && direction_reg[6] |=> !pad_oe[6])
    else $error("sync clock driven with direction 1");

  a_sync_data_dir: assert property (@(posedge clock) disable iff (rst) // see (RL16)
    serial_en && serial_sync |=> pad_oe[7] == $past(sync_serial_data_oe))
    else $error("sync data direction wrong");

  a_usb_read_off: assert property (@(posedge clock) disable iff (rst) // see (RL17)
    usb_port_off |=> pin_level_reg[4] == 1'b0 && pin_level_reg[5] == 1'b0)
    else $error("usb pins readable while usb active");

  a_usb_read_on: assert property (@(posedge clock) disable iff (rst) // see (RL17) (RL9)
    !usb_port_off |=> pin_level_reg[5:4] == $past(pad_in[5:4]))
    else $error("usb pins not readable with usb and transceiver off");

  // Drive enable and drive value must move together, or the line glitches
  sequence s_usb_minus_driven;
    pad_oe[pcp_pkg::PCP_BIT_USB_MINUS] == $past(usb_drive) &&
      pad_out[pcp_pkg::PCP_BIT_USB_MINUS] == $past(usb_minus_out);
  endsequence

  a_usb_minus_follows: assert property (@(posedge clock) disable iff (rst) // see (RL6)
    int_sel |=> s_usb_minus_driven)
    else $error("usb minus pin not following module");

  a_usb_port_input: assert property (@(posedge clock) disable iff (rst) // see (RL4)
    !usb_module_enable |=> !pad_oe[4] && !pad_oe[5])
    else $error("usb pins driven as port pins");

  a_ext_inputs_carry: assert property (@(posedge clock) disable iff (rst) // see (RL5)
    ext_sel |=> ext_xcvr_minus_in == $past(pad_in[4]) &&
      ext_xcvr_plus_in == $past(pad_in[5]))
    else $error("external transceiver inputs not passed on");

  a_sync_clk_output: assert property (@(posedge clock) disable iff (rst) // see (RL15)
    serial_en && serial_sync && !direction_reg[6] |=>
      pad_oe[6] && pad_out[6] == $past(sync_serial_clock_out))
    else $error("sync clock lost priority on bit 6");

  a_capture_input_path: assert property (@(posedge clock) disable iff (rst) // see (RL12)
    direction_reg[2] |=> ccp_capture_in == $past(pad_in[2]))
    else $error("capture input not fed from bit 2");

  a_dir_write_lands: assert property (@(posedge clock) disable iff (rst) // see (RL10) (RL18)
    dir_wr_en |=> direction_reg == ($past(reg_wr_data) & pcp_pkg::PCP_CTRL_MASK))
    else $error("direction readback differs from write");

  a_unused_bits_zero: assert property (@(posedge clock) disable iff (rst) // see (RL4) (RL18)
    output_latch_reg[5:3] == 3'h0 && direction_reg[5:4] == 2'h0)
    else $error("unimplemented register bits set");

  a_pin0_read_level: assert property (@(posedge clock) disable iff (rst) // see (RL1) (RL2)
    !timer_osc_en |=> pin_level_reg[0] == $past(pad_in[0]))
    else $error("pin 0 level not read back");
endmodule : pcp_port
`default_nettype wire

// ### tb/pcp_pad_model.sv
// Pad model: board circuits on the port pins
`timescale 1ns/1ps
`default_nettype none
module pcp_pad_model (
  // Clock
  input wire logic clock,
  // Device side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  // Board side
  input wire logic [7:0] ext_oe,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  // Undriven pins wander, so a stale level never passes for a match
  logic [7:0] float_reg = 8'h55;
  always @(posedge clock) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_oe[i] ? ext_val[i] : float_reg[i]);
    end
  end
endmodule : pcp_pad_model
`default_nettype wire

// ### tb/tb.sv
// Testbench: port block with pad model and queued expectations
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {int due; int sel; logic [7:0] mask; logic [7:0] val;} pcp_exp_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic dir_wr_en = 1'b0, latch_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00, ext_val = 8'h00, ext_oe = 8'hFF;
  logic timer_osc_en = 1'b0, ccp_out_en = 1'b0, ccp_out = 1'b0;
  logic serial_en = 1'b0, serial_sync = 1'b0, serial_tx_data = 1'b0;
  logic sync_serial_clock_out = 1'b0, sync_serial_data_out = 1'b0;
  logic sync_serial_data_oe = 1'b0;
  logic usb_module_enable = 1'b0, usb_xcvr_disable = 1'b0, usb_ext_xcvr = 1'b0;
  logic xcvr_output_enable = 1'b0, usb_drive = 1'b0;
  logic usb_minus_out = 1'b0, usb_plus_out = 1'b0;
  logic [7:0] direction_reg, output_latch_reg, pin_level_reg, pad_in, pad_out, pad_oe;
  logic timer_count_in, ccp_capture_in, sync_serial_clock_in, serial_rx_data;
  logic usb_minus_in, usb_plus_in, ext_xcvr_minus_in, ext_xcvr_plus_in;
  pcp_exp_t exp_q[$];
  pcp_exp_t e;
  logic [7:0] got, r;
  int cyc = 0, fails = 0, samples_checked = 0, seed;
  always #50 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  pcp_port u_pcp_port (.clock(clock), .rst(rst), .dir_wr_en(dir_wr_en),
    .latch_wr_en(latch_wr_en), .reg_wr_data(reg_wr_data), .direction_reg(direction_reg),
    .output_latch_reg(output_latch_reg), .pin_level_reg(pin_level_reg), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .timer_osc_en(timer_osc_en),
    .timer_count_in(timer_count_in), .ccp_out_en(ccp_out_en), .ccp_out(ccp_out),
    .ccp_capture_in(ccp_capture_in), .serial_en(serial_en), .serial_sync(serial_sync),
    .serial_tx_data(serial_tx_data), .sync_serial_clock_out(sync_serial_clock_out),
    .sync_serial_data_out(sync_serial_data_out), .sync_serial_data_oe(sync_serial_data_oe),
    .sync_serial_clock_in(sync_serial_clock_in), .serial_rx_data(serial_rx_data),
    .usb_module_enable(usb_module_enable), .usb_xcvr_disable(usb_xcvr_disable),
    .usb_ext_xcvr(usb_ext_xcvr), .xcvr_output_enable(xcvr_output_enable),
    .usb_drive(usb_drive), .usb_minus_out(usb_minus_out), .usb_plus_out(usb_plus_out),
    .usb_minus_in(usb_minus_in), .usb_plus_in(usb_plus_in),
    .ext_xcvr_minus_in(ext_xcvr_minus_in), .ext_xcvr_plus_in(ext_xcvr_plus_in));
  pcp_pad_model u_pcp_pad_model (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
    .ext_oe(ext_oe), .ext_val(ext_val), .pad_in(pad_in));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick(input int sel);
    case (sel)
      0: pick = direction_reg;
      1: pick = output_latch_reg;
      2: pick = pin_level_reg;
      3: pick = pad_oe;
      4: pick = pad_out;
      default: pick = {timer_count_in, ccp_capture_in, sync_serial_clock_in, serial_rx_data,
        usb_minus_in, usb_plus_in, ext_xcvr_minus_in, ext_xcvr_plus_in};
    endcase
  endfunction : pick
  task put(input int sel, input logic [7:0] mask, input logic [7:0] val);
    exp_q.push_back('{cyc, sel, mask, val & mask});
  endtask : put
  task wr(input logic d, input logic l, input logic [7:0] data);
    @(posedge clock);
    dir_wr_en <= d;
    latch_wr_en <= l;
    reg_wr_data <= data;
    @(posedge clock);
    dir_wr_en <= 1'b0;
    latch_wr_en <= 1'b0;
  endtask : wr
  // Three edges cover the register write plus the one-cycle pad latency
  task st;
    repeat (3) @(posedge clock);
  endtask : st
  task done(input string name);
    st();
    $display("test %s done", name);
  endtask : done
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // Result watcher
  always @(negedge clock) begin
    while (exp_q.size() > 0 && exp_q[0].due <= cyc) begin
      e = exp_q.pop_front();
      got = pick(e.sel) & e.mask;
      samples_checked++;
      if (got !== e.val) begin
        fails++;
        $display("[FAIL] t=%0t sel=%0d got %h exp %h", $time, e.sel, got, e.val);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 56861;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    usb_xcvr_disable <= 1'b1;
    @(posedge clock);
    put(0, 8'hFF, pcp_pkg::PCP_CTRL_MASK);
    put(3, 8'hFF, 8'h00);
    wr(1'b1, 1'b1, 8'hFF);
    st();
    put(0, 8'hFF, 8'hC7);
    put(1, 8'hFF, 8'hC7);
    put(2, 8'hC7, 8'h00);
    done("regs");
    repeat (4) begin
      r = 8'($random(seed));
      wr(1'b1, 1'b1, 8'h00);
      wr(1'b0, 1'b1, r);
      st();
      put(3, 8'hFF, 8'hC7);
      put(4, 8'hC7, r);
      put(2, 8'hC7, r);
      ext_val <= ~r;
      wr(1'b1, 1'b0, 8'hFF);
      st();
      put(3, 8'hFF, 8'h00);
      put(2, 8'hFF, ~r & 8'hF7);
    end
    done("direction");
    wr(1'b1, 1'b1, 8'h00);
    ccp_out_en <= 1'b1;
    ccp_out <= 1'b1;
    st();
    put(4, 8'h04, 8'h04);
    wr(1'b1, 1'b0, 8'h04);
    ext_val <= 8'h04;
    st();
    put(3, 8'h04, 8'h00);
    put(5, 8'h40, 8'h40);
    ccp_out_en <= 1'b0;
    done("ccp");
    wr(1'b1, 1'b0, 8'h00);
    timer_osc_en <= 1'b1;
    ext_val <= 8'hFF;
    st();
    put(3, 8'h03, 8'h00);
    put(0, 8'hFF, 8'h00);
    put(2, 8'h03, 8'h00);
    put(5, 8'h80, 8'h80);
    timer_osc_en <= 1'b0;
    done("osc");
    wr(1'b1, 1'b0, 8'hFF);
    usb_module_enable <= 1'b1;
    usb_ext_xcvr <= 1'b1;
    xcvr_output_enable <= 1'b1;
    usb_drive <= 1'b1;
    ext_val <= 8'h10;
    st();
    put(3, 8'h32, 8'h02);
    put(4, 8'h02, 8'h02);
    put(5, 8'h0F, 8'h02);
    put(2, 8'h30, 8'h00);
    usb_ext_xcvr <= 1'b0;
    usb_xcvr_disable <= 1'b0;
    usb_minus_out <= 1'b1;
    st();
    put(3, 8'h32, 8'h30);
    put(4, 8'h30, 8'h10);
    usb_drive <= 1'b0;
    ext_val <= 8'h20;
    st();
    put(3, 8'h30, 8'h00);
    put(5, 8'h0F, 8'h04);
    usb_module_enable <= 1'b0;
    st();
    put(2, 8'h30, 8'h00);
    usb_xcvr_disable <= 1'b1;
    done("usb");
    wr(1'b1, 1'b0, 8'h00);
    serial_en <= 1'b1;
    serial_tx_data <= 1'b1;
    st();
    put(3, 8'h40, 8'h40);
    put(4, 8'h40, 8'h40);
    serial_sync <= 1'b1;
    st();
    put(4, 8'h40, 8'h00);
    wr(1'b1, 1'b0, 8'hC0);
    ext_val <= 8'h40;
    sync_serial_data_oe <= 1'b1;
    sync_serial_data_out <= 1'b1;
    st();
    put(3, 8'hC0, 8'h80);
    put(4, 8'h80, 8'h80);
    put(5, 8'h20, 8'h20);
    sync_serial_data_oe <= 1'b0;
    ext_val <= 8'h80;
    st();
    put(3, 8'h80, 8'h00);
    put(5, 8'h10, 8'h10);
    done("serial");
    complete_run();
  end
endmodule : tb
`default_nettype wire
